// ==== logic/irq_enable_flag_bank.sv ====
// Purpose: primary control register 3 and multi-function registers 0..5 of the
//          interrupt controller, with global enable and a request to the core
// Assumes: event inputs are one-cycle pulses from logic on core_clk
// Notes:   registers sit on Avalon-MM with one wait state per access
//
// The address map and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "irq_bank_regs.svh"

// Functional notes
// - primary bits 7..4 hold request flags
// - primary bits 3..0 hold matching enables
// - bank 0 flags: timer0 compare matches
// - bank 0 enables: timer0 compare matches
// - bank 1 flags: timer1 compare matches
// - bank 1 enables: timer1 compare matches
// - bank 2: periodic timer2 flags and enables
// - banks 2, 5 unused bits read zero
// - bank 3 flags: serial, spi, eeprom, low-voltage
// - bank 3 enables for same four sources
// - bank 4 flags: std timer2, periodic timer3
// - bank 4 enables for same four sources
// - bank 5: uart1 and uart0 flags, enables
// - flags set regardless; jump needs enable
// - global enable off blocks every core request; bank_irq ignores it
// - taking an interrupt clears global enable
module irq_enable_flag_bank (
    // clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       rst_b,
    // avalon-mm slave
    input  wire logic [5:0]                 avs_address,
    input  wire logic                       avs_read,
    input  wire logic                       avs_write,
    input  wire logic [31:0]                avs_writedata,
    input  wire logic [3:0]                 avs_byteenable,
    output logic      [31:0]                avs_readdata,
    output logic                            avs_waitrequest,
    // primary sources
    input  wire logic                       ext_pin2_evt,
    input  wire logic                       ext_pin3_evt,
    // multi-function sources, [3] feeds flag bit 7
    input  wire logic [3:0]                 multifn0_evt,
    input  wire logic [3:0]                 multifn1_evt,
    input  wire logic [1:0]                 multifn2_evt,
    input  wire logic [3:0]                 multifn3_evt,
    input  wire logic [3:0]                 multifn4_evt,
    input  wire logic [1:0]                 multifn5_evt,
    // core vectoring
    input  wire logic                       irq_take,
    output logic                            irq_req,
    output irq_bank_pkg::irq_src_t          irq_src,
    output logic                            global_irq_en,
    output logic [3:0]                      multifn_hit,
    // block interrupt
    output logic                            bank_irq
);

    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    irq_bank_pkg::bank_reg_t bank_val [`NUM_BANKS];   // register images
    logic [3:0]              bank_set [`NUM_BANKS];   // set events per bank
    logic [`NUM_BANKS-1:0]   bank_wr;                 // write strobe per bank
    logic [`NUM_BANKS-1:0]   bank_hit;                // flag-and-enable per bank
    logic                    acc_ack;                 // high in the answering cycle
    logic                    acc_req;                 // a request is on the bus
    logic                    wr_fire;                 // write takes effect now
    logic                    lane0;                   // low byte lane enabled
    logic [3:0]              prim_pend;               // enabled primary requests
    logic                    take_ok;                 // core takes a live request
    logic [1:0]              blk_evt;                 // block events
    logic [1:0]              blk_status;              // block sticky status
    logic [1:0]              blk_enable;              // block enable mask
    logic [7:0]              prim_flags_q;            // primary flags, last cycle
    logic [31:0]             next_readdata;           // read mux output
    irq_bank_pkg::irq_src_t  next_irq_src;            // priority pick

    // map a byte address to a bank index, or NUM_BANKS when it is no bank
    function automatic logic [2:0] bank_index(input logic [5:0] addr);
        logic [5:0] rel;
        rel = addr - `OFS_PRIMARY_CTRL3;
        if (addr[1:0] == 2'h0 && addr <= `OFS_MULTIFN_CTRL5) begin
            bank_index = rel[4:2];
        end else begin
            bank_index = 3'(`NUM_BANKS);
        end
    endfunction : bank_index

    // ---------------------------------------------------------------
    // bus handshake
    // ---------------------------------------------------------------

    assign acc_req = avs_read | avs_write;

    // one wait state: the first cycle of a request is held off, the
    // second answers; this keeps read data registered
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            acc_ack <= 1'b0;
        end else begin
            acc_ack <= acc_req & ~acc_ack;
        end
    end

    assign avs_waitrequest = acc_req & ~acc_ack;
    assign lane0           = avs_byteenable[0];
    // only the low lane carries register bits, so writes need it
    assign wr_fire         = avs_write & acc_ack & lane0;

    // write strobe per bank, decoded once through the shared function
    // software writes every bank
    generate
        for (genvar b = 0; b < `NUM_BANKS; b++) begin : g_wr
            assign bank_wr[b] = wr_fire && (bank_index(avs_address) == 3'(b));
        end
    endgenerate

    // ---------------------------------------------------------------
    // set events into each bank
    // ---------------------------------------------------------------

    // enabled bank 4 and 5 requests raise primary flags
    // primary flags from pins and banks
    assign bank_set[0] = {bank_hit[6], bank_hit[5], ext_pin3_evt, ext_pin2_evt};
    assign bank_set[1] = multifn0_evt;
    assign bank_set[2] = multifn1_evt;
    // periodic timer2 in the low pair
    assign bank_set[3] = {2'h0, multifn2_evt};
    assign bank_set[4] = multifn3_evt;
    assign bank_set[5] = multifn4_evt;
    // uart1 and uart0 in the low pair
    assign bank_set[6] = {2'h0, multifn5_evt};

    // banks 0..3 feed primary flags held elsewhere
    assign multifn_hit = bank_hit[4:1];

    // ---------------------------------------------------------------
    // the seven flag/enable registers
    // ---------------------------------------------------------------
    // enables in bits 3..0 of every bank
    // serial group enables, timer group enables
    // flags set whatever the enable holds
    generate
        for (genvar b = 0; b < `NUM_BANKS; b++) begin : g_bank
            // banks 2 and 5 keep only the low pair
            localparam logic [3:0] IMPL = (b == 3 || b == 6) ? `IMPL_LOW_PAIR : `IMPL_FULL;
            flag_pair_reg #(
                .IMPL    (IMPL)
            ) u_bank (
                .core_clk (core_clk),
                .rst_b    (rst_b),
                .wr_en    (bank_wr[b]),
                .wr_data  (avs_writedata[7:0]),
                .set_evt  (bank_set[b]),
                .value    (bank_val[b]),
                .hit      (bank_hit[b])
            );
        end
    endgenerate

    // ---------------------------------------------------------------
    // global enable and core request
    // ---------------------------------------------------------------

    // primary requests with their own enable; flag bit 4+i pairs enable i
    // a vector needs flag and enable
    assign prim_pend = bank_val[`BANK_PRIMARY][`FLAG_MSB:`FLAG_LSB]
                     & bank_val[`BANK_PRIMARY][`EN_MSB:`EN_LSB];

    // the core may only take what is offered and still allowed
    assign take_ok = irq_take & irq_req & global_irq_en;

    // global enable: software sets or clears, taking an interrupt clears;
    // the take wins so a same-cycle write cannot reopen nesting
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            global_irq_en <= `RST_GLOBAL_EN;
        end else if (take_ok) begin
            global_irq_en <= 1'b0;
        end else if (wr_fire && avs_address == `OFS_CORE_CTRL) begin
            global_irq_en <= avs_writedata[`CORE_GLOBAL_EN_BIT];
        end
    end

    // fixed priority, lowest pair first: pin 2, pin 3, bank 4, bank 5
    always_comb begin
        next_irq_src = irq_bank_pkg::SRC_EXT_PIN2;
        if (prim_pend[0]) begin
            next_irq_src = irq_bank_pkg::SRC_EXT_PIN2;
        end else if (prim_pend[1]) begin
            next_irq_src = irq_bank_pkg::SRC_EXT_PIN3;
        end else if (prim_pend[2]) begin
            next_irq_src = irq_bank_pkg::SRC_MULTIFN4;
        end else if (prim_pend[3]) begin
            next_irq_src = irq_bank_pkg::SRC_MULTIFN5;
        end
    end

    // request to the core, registered; dropped at once after a take so
    // the core never sees a second request from the same cycle
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_req <= 1'b0;
            irq_src <= irq_bank_pkg::SRC_EXT_PIN2;
        end else begin
            irq_req <= global_irq_en & ~take_ok & (|prim_pend);
            irq_src <= next_irq_src;
        end
    end

    // ---------------------------------------------------------------
    // block interrupt: taken and new-primary-flag events
    // ---------------------------------------------------------------

    // remember primary flags to spot a fresh request
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            prim_flags_q <= `RST_BANK;
        end else begin
            prim_flags_q <= bank_val[`BANK_PRIMARY];
        end
    end

    assign blk_evt[`STAT_TAKEN_BIT]  = take_ok;
    assign blk_evt[`STAT_NEWREQ_BIT] = |(bank_val[`BANK_PRIMARY][`FLAG_MSB:`FLAG_LSB]
                                       & ~prim_flags_q[`FLAG_MSB:`FLAG_LSB]);

    irq_status_block #(
        .W        (2)
    ) u_status (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .evt      (blk_evt),
        .clr_wr   (wr_fire && avs_address == `OFS_IRQ_CLEAR),
        .en_wr    (wr_fire && avs_address == `OFS_IRQ_ENABLE),
        .wr_data  (avs_writedata[1:0]),
        .status   (blk_status),
        .enable   (blk_enable),
        .irq      (bank_irq)
    );

    // ---------------------------------------------------------------
    // read path
    // ---------------------------------------------------------------

    // read mux; unmapped and write-only addresses read zero
    always_comb begin
        next_readdata = 32'h0000_0000;
        if (bank_index(avs_address) != 3'(`NUM_BANKS)) begin
            // unused bits already zero in the image
            next_readdata[7:0] = bank_val[bank_index(avs_address)];
        end else begin
            case (avs_address)
                `OFS_CORE_CTRL: begin
                    next_readdata[`CORE_GLOBAL_EN_BIT] = global_irq_en;
                end
                `OFS_IRQ_STATUS: begin
                    next_readdata[1:0] = blk_status;
                end
                `OFS_IRQ_ENABLE: begin
                    next_readdata[1:0] = blk_enable;
                end
                `OFS_VECTOR_STATUS: begin
                    next_readdata[2:0] = {irq_src, irq_req};
                end
                default: begin
                    next_readdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // capture in the held-off cycle so data stand at the answering edge
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !acc_ack) begin
            avs_readdata <= next_readdata;
        end
    end

endmodule : irq_enable_flag_bank
`default_nettype wire

// ==== logic/irq_bank_regs.svh ====
// Purpose: register offsets, field positions and reset values of the interrupt flag bank
// Assumes: 32-bit Avalon-MM data with byte addressing, byte addresses below
// Notes:   definitions only, no logic
`ifndef IRQ_BANK_REGS_SVH
`define IRQ_BANK_REGS_SVH

// byte offsets of the registers
`define OFS_PRIMARY_CTRL3    6'h00
`define OFS_MULTIFN_CTRL0    6'h04
`define OFS_MULTIFN_CTRL5    6'h18
`define OFS_CORE_CTRL        6'h1C
`define OFS_IRQ_STATUS       6'h20
`define OFS_IRQ_CLEAR        6'h24
`define OFS_IRQ_ENABLE       6'h28
`define OFS_VECTOR_STATUS    6'h2C

// number of flag/enable banks: primary plus six multi-function
`define NUM_BANKS            7
`define BANK_PRIMARY         3'h0

// flag nibble sits in bits 7..4, enable nibble in bits 3..0
`define FLAG_MSB             7
`define FLAG_LSB             4
`define EN_MSB               3
`define EN_LSB               0

// implemented pairs per bank, one bit per flag/enable pair
`define IMPL_FULL            4'hF
`define IMPL_LOW_PAIR        4'h3

// reset values
`define RST_BANK             8'h00
`define RST_GLOBAL_EN        1'h0
`define RST_IRQ_BITS         2'h0

// core control and block-status field positions
`define CORE_GLOBAL_EN_BIT   0
`define STAT_TAKEN_BIT       0
`define STAT_NEWREQ_BIT      1

`endif

// ==== logic/irq_bank_pkg.sv ====
// Purpose: shared types of the interrupt flag bank
// Assumes: constants live in irq_bank_regs.svh
// Notes:   nothing here is imported; users write irq_bank_pkg::name
package irq_bank_pkg;

    // one 8-bit flag/enable register image
    typedef logic [7:0] bank_reg_t;

    // vector chosen among the primary sources of this bank
    typedef enum logic [1:0] {
        SRC_EXT_PIN2 = 2'b00,
        SRC_EXT_PIN3 = 2'b01,
        SRC_MULTIFN4 = 2'b10,
        SRC_MULTIFN5 = 2'b11
    } irq_src_t;

endpackage : irq_bank_pkg

// ==== logic/flag_pair_reg.sv ====
// Purpose: one register of four request flags (7..4) and four enables (3..0)
// Assumes: set events come from logic on core_clk
// Notes:   unimplemented pairs read as zero and ignore writes
`timescale 1ns/1ps
`default_nettype none
`include "irq_bank_regs.svh"

module flag_pair_reg #(
    parameter logic [3:0] IMPL = `IMPL_FULL   // which flag/enable pairs exist
) (
    // clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      rst_b,
    // software side
    input  wire logic                      wr_en,      // write strobe, one cycle
    input  wire logic [7:0]                wr_data,    // value written
    // hardware side
    input  wire logic [3:0]                set_evt,    // flag set, [3] is bit 7
    output irq_bank_pkg::bank_reg_t        value,      // register image
    output logic                           hit         // some flag and its enable both set
);

    logic [3:0] flags;   // request flags
    logic [3:0] enables; // enable bits

    // flags: software may write, a set event in the same cycle wins
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            flags <= 4'(`RST_BANK >> 4);
        end else if (wr_en) begin
            flags <= (wr_data[`FLAG_MSB:`FLAG_LSB] | set_evt) & IMPL;
        end else begin
            flags <= (flags | set_evt) & IMPL;
        end
    end

    // enables: software only
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            enables <= 4'h0;
        end else if (wr_en) begin
            enables <= wr_data[`EN_MSB:`EN_LSB] & IMPL;
        end
    end

    assign value = {flags, enables};
    assign hit   = |(flags & enables);

endmodule : flag_pair_reg
`default_nettype wire

// ==== logic/irq_status_block.sv ====
// Purpose: sticky block-event status, write-one-to-clear, enable mask, one level irq
// Assumes: events are one-cycle pulses on core_clk
// Notes:   an event in the cycle of its clear stays set
`timescale 1ns/1ps
`default_nettype none

module irq_status_block #(
    parameter int W = 2   // number of event bits
) (
    // clock and reset
    input  wire logic          core_clk,
    input  wire logic          rst_b,
    // events
    input  wire logic [W-1:0]  evt,       // one-cycle event pulses
    // software side
    input  wire logic          clr_wr,    // write to the clear register
    input  wire logic          en_wr,     // write to the enable register
    input  wire logic [W-1:0]  wr_data,   // written bits
    output logic      [W-1:0]  status,    // sticky status
    output logic      [W-1:0]  enable,    // enable mask
    output logic               irq        // level interrupt
);

    // status: set beats clear
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            status <= '0;
        end else begin
            status <= (status & ~(clr_wr ? wr_data : '0)) | evt;
        end
    end

    // enable mask
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            enable <= '0;
        end else if (en_wr) begin
            enable <= wr_data;
        end
    end

    assign irq = |(status & enable);

endmodule : irq_status_block
`default_nettype wire

// ==== testbench/irq_bank_checker_asserts.sv ====
// Purpose: port-level checks of the interrupt flag bank
// Assumes: one clock domain, async active-low reset
// Notes:   bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
`include "irq_bank_regs.svh"

module irq_bank_checker (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        rst_b,
    // register bus
    input wire logic [5:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // core side
    input wire logic        irq_take,
    input wire logic        irq_req,
    input wire logic        global_irq_en,
    input wire logic [3:0]  multifn_hit
);
    // an access completes at an edge with waitrequest low
    wire logic wr_done = avs_write && !avs_waitrequest;
    wire logic rd_done = avs_read && !avs_waitrequest;
    // banks 2 and 5 carry only their low pairs
    wire logic gap_reg = avs_address == 6'h0C || avs_address == `OFS_MULTIFN_CTRL5;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    chk_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("access kept more than one wait state");
    chk_upper_zero: assert property (rd_done |-> avs_readdata[31:8] == 24'h0)
        else $error("read data above bit 7 not zero");
    chk_gap_bits: assert property (rd_done && gap_reg |-> (avs_readdata[7:6] | avs_readdata[3:2]) == 2'h0)
        else $error("unimplemented bits read nonzero");
    chk_take_clears: assert property (irq_take && irq_req && global_irq_en |=> !global_irq_en && !irq_req)
        else $error("take left global enable or request set");
    chk_global_blocks: assert property (!global_irq_en [*2] |-> !irq_req)
        else $error("request while global enable off");
    chk_global_by_sw: assert property ($rose(global_irq_en) |-> $past(wr_done))
        else $error("global enable set without a write");
    chk_hit_sticky: assert property ($fell(|multifn_hit) |-> $past(wr_done))
        else $error("bank hit dropped without a write");
    chk_req_sticky: assert property ($fell(irq_req) |-> $past(irq_take) || $past(wr_done) || $past(wr_done, 2))
        else $error("request dropped unprompted");

    cov_take: cover property (irq_take && irq_req && global_irq_en);
    cov_gap_read: cover property (rd_done && gap_reg);
    cov_hit: cover property (|multifn_hit);
endmodule : irq_bank_checker

bind irq_enable_flag_bank irq_bank_checker irq_bank_checker_i (
    .core_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
    .irq_take, .irq_req, .global_irq_en, .multifn_hit
);
`default_nettype wire

// ==== testbench/irq_far_side_model.sv ====
// Purpose: event sources and the core's take, seen from the bank
// Assumes: events leave as one-cycle pulses on core_clk
// Notes:   a core that is off never takes
`timescale 1ns/1ps
`default_nettype none

module irq_far_side_model #(
    parameter int TAKE_DELAY = 3   // cycles the core sits on a request
) (
    // clock and reset
    input wire logic         core_clk,
    input wire logic         rst_b,
    // bench commands
    input wire logic [21:0]  fire,      // events to pulse
    input wire logic         take_on,   // core answers requests
    // bank side
    input wire logic         irq_req,
    input wire logic         global_irq_en,
    output logic [21:0]      evt,
    output logic             irq_take
);
    logic [3:0] wait_cnt;   // cycles the request has waited

    // sources: a command becomes one pulse
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            evt <= 22'h0;
        end else begin
            evt <= fire;
        end
    end

    // core: takes only an offered request, after a delay
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_cnt <= 4'h0;
            irq_take <= 1'h0;
        end else if (irq_take || !(irq_req && global_irq_en && take_on)) begin
            wait_cnt <= 4'h0;
            irq_take <= 1'h0;
        end else if (wait_cnt == 4'(TAKE_DELAY)) begin
            irq_take <= 1'h1;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule : irq_far_side_model
`default_nettype wire

// ==== testbench/irq_enable_flag_bank_test.sv ====
// Purpose: self-checking bench of the interrupt flag bank
// Assumes: one wait state per access, event pulses from the model
// Notes:   outputs are snapshot mid-cycle to stay clear of edge races
`timescale 1ns/1ps
`default_nettype none
`include "irq_bank_regs.svh"

module irq_enable_flag_bank_test;
    // register index and flag bit of each event, pin2 first
    localparam int EV_REG [22] = '{0, 0, 1, 1, 1, 1, 2, 2, 2, 2, 3, 3, 4, 4, 4, 4, 5, 5, 5, 5, 6, 6};
    localparam int EV_BIT [22] = '{4, 5, 4, 5, 6, 7, 4, 5, 6, 7, 4, 5, 4, 5, 6, 7, 4, 5, 6, 7, 4, 5};
    localparam int BASE [6] = '{2, 6, 10, 12, 16, 20};   // first event of each bank
    logic core_clk = 1'h0, rst_b = 1'h0, avs_read = 1'h0, avs_write = 1'h0, take_on = 1'h0;
    logic [5:0] avs_address = 6'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic [3:0] avs_byteenable = 4'hF, multifn_hit, s_hit;
    logic [21:0] fire = 22'h0, evt;   // commands to the model, pulses out of it
    logic avs_waitrequest, irq_take, irq_req, global_irq_en, bank_irq, s_req, s_glob, s_bank;
    logic [1:0] s_src;
    irq_bank_pkg::irq_src_t irq_src;
    int errors = 0;
    int tests_run = 0;

    always #2.5 core_clk = ~core_clk;

    // snapshot outputs mid-cycle, away from the launching edge
    always @(negedge core_clk) begin
        {s_req, s_glob, s_bank, s_src, s_hit} <= {irq_req, global_irq_en, bank_irq, irq_src, multifn_hit};
    end

    irq_enable_flag_bank irq_enable_flag_bank_i (
        .core_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .ext_pin2_evt(evt[0]), .ext_pin3_evt(evt[1]),
        .multifn0_evt(evt[5:2]), .multifn1_evt(evt[9:6]), .multifn2_evt(evt[11:10]),
        .multifn3_evt(evt[15:12]), .multifn4_evt(evt[19:16]), .multifn5_evt(evt[21:20]),
        .irq_take, .irq_req, .irq_src, .global_irq_en, .multifn_hit, .bank_irq);
    irq_far_side_model irq_far_side_model_i (.core_clk, .rst_b, .fire, .take_on, .irq_req, .global_irq_en,
        .evt, .irq_take);

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
            errors++;
        end
    endtask : check

    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : results

    // one access, held until waitrequest is seen low; a hang ends the run
    task automatic bus(input logic is_wr, input logic [5:0] a, input logic [7:0] d, input logic [3:0] be);
        int n;
        n = 0;
        {avs_address, avs_write, avs_read} <= {a, is_wr, !is_wr};
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'h0 && n < 16);
        if (avs_waitrequest !== 1'h0) begin
            errors++;
            results();
        end
        rd = avs_readdata;
        {avs_read, avs_write} <= 2'h0;
        @(posedge core_clk);
    endtask : bus

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        bus(1'h1, a, d, 4'hF);
    endtask : wr

    task automatic rdc(input string what, input logic [5:0] a, input logic [31:0] exp);
        bus(1'h0, a, 8'h00, 4'hF);
        check(what, rd, exp);
    endtask : rdc

    // ask the model for one event pulse, then let the flag settle
    task automatic pulse(input int idx);
        fire <= 22'h1 << idx;
        @(posedge core_clk);
        fire <= 22'h0;
        repeat (4) @(posedge core_clk);
    endtask : pulse

    task automatic t_regs;
        for (int k = 0; k < 8; k++) rdc("reset value", 6'(4 * k), 32'h0);
        for (int k = 0; k < 7; k++) begin
            wr(6'(4 * k), 8'hFF);
            rdc("written value", 6'(4 * k), (k == 3 || k == 6) ? 32'h33 : 32'hFF);
        end
        bus(1'h1, 6'h10, 8'h00, 4'hE);
        rdc("lane off write", 6'h10, 32'hFF);
        // clear the banks before the primary, whose top flags follow them
        for (int k = 6; k >= 0; k--) begin
            wr(6'(4 * k), 8'h00);
            rdc("cleared value", 6'(4 * k), 32'h0);
        end
        wr(6'h30, 8'hFF);
        rdc("unmapped", 6'h30, 32'h0);
    endtask : t_regs

    task automatic t_events;
        for (int i = 0; i < 22; i++) begin
            pulse(i);
            rdc("event flag", 6'(4 * EV_REG[i]), 32'h1 << EV_BIT[i]);
            check("no request", s_req, 1'h0);
            wr(6'(4 * EV_REG[i]), 8'h00);
        end
    endtask : t_events

    task automatic t_enables;
        for (int k = 0; k < 6; k++) begin
            for (int j = 0; j < ((k == 2 || k == 5) ? 2 : 4); j++) begin
                wr(6'(4 * k + 4), 8'(1 << j));
                pulse(BASE[k] + (j ^ 1));
                check("unpaired hit", s_hit, 4'h0);
                pulse(BASE[k] + j);
                check("bank hit", s_hit, (k < 4) ? 4'(1 << k) : 4'h0);
                if (k >= 4) rdc("primary flag", 6'h00, 32'(1 << (k + 2)));
                wr(6'(4 * k + 4), 8'h00);
                wr(6'h00, 8'h00);
            end
        end
    endtask : t_enables

    task automatic t_take;
        wr(`OFS_MULTIFN_CTRL5, 8'h01);
        wr(`OFS_PRIMARY_CTRL3, 8'h08);
        wr(`OFS_IRQ_CLEAR, 8'h03);
        pulse(20);
        check("held by global off", s_req, 1'h0);
        wr(`OFS_CORE_CTRL, 8'h01);
        @(posedge core_clk);
        check("request raised", s_req, 1'h1);
        check("vector source", s_src, irq_bank_pkg::SRC_MULTIFN5);
        take_on <= 1'h1;
        for (int n = 0; s_glob !== 1'h0; n++) begin
            if (n == 20) begin
                errors++;
                results();
            end
            @(posedge core_clk);
        end
        take_on <= 1'h0;
        check("request dropped", s_req, 1'h0);
        pulse(0);
        rdc("flag while serviced", `OFS_PRIMARY_CTRL3, 32'h98);
        check("no nesting", s_req, 1'h0);
        rdc("block status", `OFS_IRQ_STATUS, 32'h3);
        check("masked block irq", s_bank, 1'h0);
        wr(`OFS_IRQ_ENABLE, 8'h01);
        check("block irq", s_bank, 1'h1);
        wr(`OFS_IRQ_CLEAR, 8'h01);
        check("block irq cleared", s_bank, 1'h0);
        rdc("status cleared", `OFS_IRQ_STATUS, 32'h2);
        rdc("clear reads zero", `OFS_IRQ_CLEAR, 32'h0);
        wr(`OFS_PRIMARY_CTRL3, 8'h99);
        wr(`OFS_CORE_CTRL, 8'h01);
        @(posedge core_clk);
        check("pin2 first", s_src, irq_bank_pkg::SRC_EXT_PIN2);
        rdc("vector", `OFS_VECTOR_STATUS, 32'h1);
        wr(`OFS_CORE_CTRL, 8'h00);
        @(posedge core_clk);
        check("global off drops", s_req, 1'h0);
    endtask : t_take

    initial begin
        repeat (4) @(posedge core_clk);
        rst_b <= 1'h1;
        @(posedge core_clk);
        t_regs();
        $display("done: register access");
        t_events();
        $display("done: event flags");
        t_enables();
        $display("done: enable pairing");
        t_take();
        $display("done: take and global enable");
        results();
    end
endmodule : irq_enable_flag_bank_test
`default_nettype wire
